// ==== src/eap_pkg.sv ====
// constants, types and helpers for the error priority alarm block
package eap_pkg;
    // register bus geometry
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam int unsigned NERR = 16;
    localparam int unsigned NB = 8;
    localparam int unsigned FC_W = 8;
    localparam int unsigned IRQ_W = 4;
    // register byte addresses
    localparam logic [7:0] A_ERR = 8'h00;
    localparam logic [7:0] A_PRIO_HI = 8'h04;
    localparam logic [7:0] A_PRIO_LO = 8'h08;
    localparam logic [7:0] A_MON_EN = 8'h0C;
    localparam logic [7:0] A_MON_FULL = 8'h10;
    localparam logic [7:0] A_MAINS = 8'h14;
    localparam logic [7:0] A_FUNC = 8'h18;
    localparam logic [7:0] A_IRQ_STAT = 8'h1C;
    localparam logic [7:0] A_IRQ_MASK = 8'h20;
    localparam logic [7:0] A_ALARM = 8'h24;
    localparam logic [7:0] A_BOARD = 8'h28;
    // error vector index = documented bit number - 1
    localparam int unsigned ERR_RADIO = 8;
    localparam int unsigned ERR_FULL = 11;
    localparam int unsigned ERR_ANY = 12;
    // function control bits enabling the dynamic output
    localparam int unsigned FC_DYN_HI = 5;
    localparam int unsigned FC_DYN_LO = 4;
    // interrupt status bits
    localparam int unsigned IRQ_MAJOR = 0;
    localparam int unsigned IRQ_MINOR = 1;
    localparam int unsigned IRQ_CLEAR = 2;
    localparam int unsigned IRQ_NEW = 3;
    // time base
    localparam int unsigned CLK_NS = 4;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYC = MS_NS / CLK_NS;
    localparam int unsigned CYC_W = 18;
    localparam int unsigned MS_W = 10;
    localparam int unsigned WAVE_MS = 1000;
    localparam int unsigned SHORT_MS = 20;
    localparam int unsigned LONG_MS = WAVE_MS - SHORT_MS;

    typedef enum logic [1:0] {SEV_NONE, SEV_MINOR, SEV_MAJOR} eap_sev_e;

    // high priority wins over low; bits with neither are ignored
    function automatic eap_sev_e eap_severity(input logic [NERR-1:0] e, input logic [NERR-1:0] hi,
                                             input logic [NERR-1:0] lo);
        if ((e & hi) != '0) begin
            return SEV_MAJOR;
        end else if ((e & lo) != '0) begin
            return SEV_MINOR;
        end
        return SEV_NONE;
    endfunction
endpackage

// ==== src/eap_wave_if.sv ====
// link between alarm control and the waveform generator
`timescale 1ns/1ps
interface eap_wave_if;
    import eap_pkg::*;
    logic dyn_en;
    eap_sev_e sev;
    logic ms_tick;
    logic [MS_W-1:0] ms_idx;
    logic wave;
    modport gen (input dyn_en, input sev, output ms_tick, output ms_idx, output wave);
    modport ctl (output dyn_en, output sev, input ms_tick, input ms_idx, input wave);
endinterface

// ==== src/eap_wave_gen.sv ====
// millisecond time base and alarm waveform generator
`timescale 1ns/1ps
module eap_wave_gen import eap_pkg::*; #(
    parameter int unsigned MS_CYCLES = MS_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    eap_wave_if.gen w
);
    logic [CYC_W-1:0] cyc_q;
    logic [MS_W-1:0] ms_q;
    logic tick_q;
    logic wave_q;
    logic wave_d;
    logic cyc_end;

    assign cyc_end = (cyc_q == CYC_W'(MS_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cyc_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cyc_q <= cyc_end ? '0 : cyc_q + 1'b1;
            tick_q <= cyc_end;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ms_q <= '0;
        end else if (cyc_end) begin
            ms_q <= (ms_q == MS_W'(WAVE_MS - 1)) ? '0 : ms_q + 1'b1;
        end
    end

    always_comb begin
        wave_d = 1'b0;
        if (w.dyn_en) begin
            case (w.sev)
                SEV_NONE: wave_d = (ms_q < MS_W'(LONG_MS));
                SEV_MINOR: wave_d = (ms_q < MS_W'(SHORT_MS));
                SEV_MAJOR: wave_d = 1'b0;
                default: wave_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end

    assign w.wave = wave_q;
    assign w.ms_tick = tick_q;
    assign w.ms_idx = ms_q;

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_ms_wrap;
        cyc_end && ms_q == MS_W'(WAVE_MS - 1) |=> ms_q == '0;
    endproperty
    a_ms_wrap: assert property (p_ms_wrap) else $error("ms index did not wrap");

    property p_minor_low;
        w.dyn_en && w.sev == SEV_MINOR && ms_q >= MS_W'(SHORT_MS) |=> !wave_q;
    endproperty
    a_minor_low: assert property (p_minor_low) else $error("minor pattern high too long");
endmodule

// ==== src/eap_alarm_top.sv ====
// error collection, priority weighting and alarm output
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module eap_alarm_top import eap_pkg::*; #(
    parameter int unsigned MS_CYCLES = MS_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic [NERR-1:0] src_err,
    input wire logic radio_sync,
    input wire logic [NB-1:0] board_fault,
    input wire logic [NB-1:0] board_absent,
    input wire logic [NB-1:0] mains_lost,
    output logic front_alarm_connector,
    output logic alarm_irq
);
    logic [NERR-1:0] prio_hi_q;
    logic [NERR-1:0] prio_lo_q;
    logic [NB-1:0] mon_en_q;
    logic [NB-1:0] mon_full_q;
    logic [NB-1:0] mains_q;
    logic [FC_W-1:0] func_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] stat_d;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] mask_d;
    logic [IRQ_W-1:0] ev;
    logic [NERR-1:0] err_q;
    logic [NERR-1:0] err_d;
    logic [NB-1:0] bad;
    logic [NB-1:0] bad_q;
    logic full_bad;
    logic idle_bad;
    eap_sev_e sev_q;
    eap_sev_e sev_d;
    logic dyn_en;
    logic irq_q;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;

    eap_wave_if w ();

    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ref_a);
        return a == ref_a;
    endfunction

    // board health, one slice per slot
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++) begin : g_board
            assign bad[gi] = board_fault[gi] | board_absent[gi] | (mains_q[gi] & mains_lost[gi]);
        end
    endgenerate

    assign full_bad = |(bad & mon_en_q & mon_full_q);
    assign idle_bad = |(bad & mon_en_q & ~mon_full_q);

    always_comb begin
        err_d = src_err;
        err_d[ERR_RADIO] = !radio_sync;
        err_d[ERR_FULL] = full_bad;
        err_d[ERR_ANY] = full_bad | idle_bad;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            err_q <= '0;
            bad_q <= '0;
        end else begin
            err_q <= err_d;
            bad_q <= bad;
        end
    end

    assign sev_d = eap_severity(err_q, prio_hi_q, prio_lo_q);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sev_q <= SEV_NONE;
        end else begin
            sev_q <= sev_d;
        end
    end

    assign dyn_en = func_q[FC_DYN_HI] & func_q[FC_DYN_LO];

    assign w.dyn_en = dyn_en;
    assign w.sev = sev_q;

    eap_wave_gen #(.MS_CYCLES(MS_CYCLES)) u_gen (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .w(w.gen)
    );

    assign front_alarm_connector = w.wave;

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prio_hi_q <= '0;
            prio_lo_q <= '0;
            mon_en_q <= '0;
            mon_full_q <= '0;
            mains_q <= '0;
            func_q <= '0;
        end else if (reg_wr) begin
            if (hit(reg_addr, A_PRIO_HI)) begin
                prio_hi_q <= reg_wdata[NERR-1:0];
            end
            if (hit(reg_addr, A_PRIO_LO)) begin
                prio_lo_q <= reg_wdata[NERR-1:0];
            end
            if (hit(reg_addr, A_MON_EN)) begin
                mon_en_q <= reg_wdata[NB-1:0];
            end
            if (hit(reg_addr, A_MON_FULL)) begin
                mon_full_q <= reg_wdata[NB-1:0];
            end
            if (hit(reg_addr, A_MAINS)) begin
                mains_q <= reg_wdata[NB-1:0];
            end
            if (hit(reg_addr, A_FUNC)) begin
                func_q <= reg_wdata[FC_W-1:0];
            end
        end
    end

    // next mask worked out ahead, so the interrupt follows a mask write on the same edge
    always_comb begin
        mask_d = mask_q;
        if (reg_wr && hit(reg_addr, A_IRQ_MASK)) begin
            mask_d = reg_wdata[IRQ_W-1:0];
        end
    end

    // interrupt events from severity changes and new error bits
    always_comb begin
        ev = '0;
        ev[IRQ_MAJOR] = (sev_d == SEV_MAJOR) && (sev_q != SEV_MAJOR);
        ev[IRQ_MINOR] = (sev_d == SEV_MINOR) && (sev_q != SEV_MINOR);
        ev[IRQ_CLEAR] = (sev_d == SEV_NONE) && (sev_q != SEV_NONE);
        ev[IRQ_NEW] = |(err_d & ~err_q);
    end

    // a set in the clearing cycle survives the write-one-to-clear
    always_comb begin
        stat_d = stat_q;
        if (reg_wr && hit(reg_addr, A_IRQ_STAT)) begin
            stat_d = stat_q & ~reg_wdata[IRQ_W-1:0];
        end
        stat_d = stat_d | ev;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
        end
    end

    assign alarm_irq = irq_q;

    // read data valid only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                A_ERR: rdata_d = {16'h0000, err_q};
                A_PRIO_HI: rdata_d = {16'h0000, prio_hi_q};
                A_PRIO_LO: rdata_d = {16'h0000, prio_lo_q};
                A_MON_EN: rdata_d = {24'h000000, mon_en_q};
                A_MON_FULL: rdata_d = {24'h000000, mon_full_q};
                A_MAINS: rdata_d = {24'h000000, mains_q};
                A_FUNC: rdata_d = {24'h000000, func_q};
                A_IRQ_STAT: rdata_d = {28'h0000000, stat_q};
                A_IRQ_MASK: rdata_d = {28'h0000000, mask_q};
                A_ALARM: rdata_d = {16'h0000, w.ms_idx, 2'h0, dyn_en, w.wave, sev_q};
                A_BOARD: rdata_d = {24'h000000, bad_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_full_both;
        full_bad |=> err_q[ERR_FULL] && err_q[ERR_ANY];
    endproperty
    a_full_both: assert property (p_full_both) else $error("full fault missed bit 12 or 13");

    property p_idle_only;
        idle_bad && !full_bad |=> err_q[ERR_ANY] && !err_q[ERR_FULL];
    endproperty
    a_idle_only: assert property (p_idle_only) else $error("idle fault handled wrongly");

    property p_prio;
        (err_q & prio_hi_q) == '0 && (err_q & prio_lo_q) != '0 |=> sev_q == SEV_MINOR;
    endproperty
    a_prio: assert property (p_prio) else $error("low priority error not minor");

    property p_radio;
        !radio_sync |=> err_q[ERR_RADIO];
    endproperty
    a_radio: assert property (p_radio) else $error("bit 9 not set on sync loss");

    property p_full_src;
        !full_bad |=> !err_q[ERR_FULL];
    endproperty
    a_full_src: assert property (p_full_src) else $error("bit 12 without full board fault");

    property p_mains;
        |(mains_q & mains_lost & mon_en_q & mon_full_q) |=> err_q[ERR_FULL] && |bad_q;
    endproperty
    a_mains: assert property (p_mains) else $error("lost mains not reported");

    property p_dyn_off;
        !dyn_en |=> !front_alarm_connector;
    endproperty
    a_dyn_off: assert property (p_dyn_off) else $error("alarm driven while disabled");

    property p_major_low;
        (dyn_en && sev_q == SEV_MAJOR) [*2] |=> !front_alarm_connector;
    endproperty
    a_major_low: assert property (p_major_low) else $error("major pattern not low");

    property p_prio_hi;
        (err_q & prio_hi_q) != '0 |=> sev_q == SEV_MAJOR;
    endproperty
    a_prio_hi: assert property (p_prio_hi) else $error("high priority error not major");

    property p_major_wins;
        (err_q & prio_hi_q) != '0 && (err_q & prio_lo_q) != '0 |=> sev_q == SEV_MAJOR;
    endproperty
    a_major_wins: assert property (p_major_wins) else $error("major did not win");

    property p_unprio;
        (err_q & (prio_hi_q | prio_lo_q)) == '0 |=> sev_q == SEV_NONE;
    endproperty
    a_unprio: assert property (p_unprio) else $error("unprioritised error raised alarm");

    property p_none_high;
        dyn_en && sev_q == SEV_NONE && w.ms_idx < MS_W'(LONG_MS) ##1
            dyn_en && sev_q == SEV_NONE && w.ms_idx < MS_W'(LONG_MS) |-> front_alarm_connector;
    endproperty
    a_none_high: assert property (p_none_high) else $error("no-error pattern not high");

    property p_irq;
        (stat_q & mask_q) != '0 |-> alarm_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_irq_low;
        (stat_q & mask_q) == '0 |-> !alarm_irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt without unmasked status");

    // set beats a clear in the same cycle
    property p_set_wins;
        ev[IRQ_NEW] |=> stat_q[IRQ_NEW];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost");

    property p_rd_idle;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_radio_ok;
        radio_sync |=> !err_q[ERR_RADIO];
    endproperty
    a_radio_ok: assert property (p_radio_ok) else $error("bit 9 set while synchronous");

    property p_unsup;
        (bad & mon_en_q) == '0 |=> !err_q[ERR_ANY] && !err_q[ERR_FULL];
    endproperty
    a_unsup: assert property (p_unsup) else $error("board bits without supervised fault");

    property p_minor_high;
        dyn_en && sev_q == SEV_MINOR && w.ms_idx < MS_W'(SHORT_MS) |=> front_alarm_connector;
    endproperty
    a_minor_high: assert property (p_minor_high) else $error("minor pattern pulse missing");

    property p_none_low;
        dyn_en && sev_q == SEV_NONE && w.ms_idx >= MS_W'(LONG_MS) |=> !front_alarm_connector;
    endproperty
    a_none_low: assert property (p_none_low) else $error("no-error pattern gap missing");

    c_major: cover property (dyn_en && sev_q == SEV_MAJOR);
    c_minor_pulse: cover property (dyn_en && sev_q == SEV_MINOR && $rose(front_alarm_connector));
    c_none_pulse: cover property (dyn_en && sev_q == SEV_NONE && $fell(front_alarm_connector));
    c_idle: cover property (idle_bad && !full_bad);
    c_irq: cover property (alarm_irq);
endmodule

// ==== bench/eap_alarm_mon.sv ====
// alarm monitor model: measures run lengths of the alarm pin levels
`timescale 1ns/1ps
module eap_alarm_mon (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic alarm_in,
    output int hi_len,
    output int lo_len,
    output int run_len
);
    logic last_q;

    // a switchover box only judges whole runs, so hi_len and lo_len take only completed runs; run_len counts the current one
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            last_q <= 1'b0;
            run_len <= 0;
            hi_len <= 0;
            lo_len <= 0;
        end else if (alarm_in != last_q) begin
            last_q <= alarm_in;
            run_len <= 1;
            if (last_q) begin
                hi_len <= run_len;
            end else begin
                lo_len <= run_len;
            end
        end else begin
            run_len <= run_len + 1;
        end
    end
endmodule

// ==== bench/eap_tb.sv ====
// self-checking testbench for the error priority alarm block
`timescale 1ns/1ps
module testbench;
    import eap_pkg::*;
    localparam int MS_T = 4;
    localparam logic [DW-1:0] B13 = 32'h0000_1000;
    localparam logic [DW-1:0] B12_13 = 32'h0000_1800;
    logic ref_clk;
    logic nrst;
    logic reg_wr;
    logic reg_rd;
    logic radio_sync;
    logic pin;
    logic irq;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic [DW-1:0] reg_rdata;
    logic [DW-1:0] rd_v;
    logic [NERR-1:0] src_err;
    logic [NB-1:0] bf;
    logic [NB-1:0] ba;
    logic [NB-1:0] ml;
    int error_cnt = 0;
    int total_checks = 0;
    int hi_len;
    int lo_len;
    int run_len;

    eap_alarm_top #(.MS_CYCLES(MS_T)) eap_alarm_top_inst (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_err(src_err),
        .radio_sync(radio_sync), .board_fault(bf), .board_absent(ba), .mains_lost(ml),
        .front_alarm_connector(pin), .alarm_irq(irq)
    );

    eap_alarm_mon eap_alarm_mon_inst (
        .ref_clk(ref_clk), .nrst(nrst), .alarm_in(pin),
        .hi_len(hi_len), .lo_len(lo_len), .run_len(run_len)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic settle;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic t_reset;
        rd(A_ERR, rd_v);
        chk(rd_v, '0, "err after reset");
        rd(A_FUNC, rd_v);
        chk(rd_v, '0, "func after reset");
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, rd_v);
        chk(rd_v, '0, "unmapped read");
        chk({31'h0, pin}, '0, "pin after reset");
        chk({31'h0, irq}, '0, "irq after reset");
    endtask

    task automatic bcase(input logic [NB-1:0] f, input logic [NB-1:0] a, input logic [NB-1:0] m,
                         input logic [DW-1:0] exp);
        bf <= f;
        ba <= a;
        ml <= m;
        settle;
        rd(A_ERR, rd_v);
        chk(rd_v, exp, "board error bits");
    endtask

    task automatic t_boards;
        wr(A_MON_EN, 32'h0000_000F);
        wr(A_MON_FULL, 32'h0000_0005);
        wr(A_MAINS, 32'h0000_0004);
        bcase(8'h02, 8'h00, 8'h00, B13);
        bcase(8'h00, 8'h02, 8'h00, B13);
        bcase(8'h01, 8'h00, 8'h00, B12_13);
        bcase(8'h00, 8'h01, 8'h00, B12_13);
        bcase(8'h00, 8'h00, 8'h04, B12_13);
        rd(A_BOARD, rd_v);
        chk(rd_v, 32'h0000_0004, "board health");
        bcase(8'h00, 8'h04, 8'h00, B12_13);
        bcase(8'h00, 8'h00, 8'h01, '0);
        bcase(8'h10, 8'h00, 8'h00, '0);
        bcase(8'h00, 8'h00, 8'h00, '0);
        radio_sync <= 1'b0;
        src_err <= 16'h0001;
        settle;
        rd(A_ERR, rd_v);
        chk(rd_v, 32'h0000_0101, "radio loss bit");
        radio_sync <= 1'b1;
        src_err <= '0;
    endtask

    // k: 0 no error, 1 minor, 2 steady low
    task automatic pat(input int k);
        repeat (8500) @(posedge ref_clk);
        #1;
        if (k == 0) begin
            chk(hi_len, LONG_MS * MS_T, "no error high run");
            chk(lo_len, SHORT_MS * MS_T, "no error low run");
        end else if (k == 1) begin
            chk(hi_len, SHORT_MS * MS_T, "minor high run");
            chk(lo_len, LONG_MS * MS_T, "minor low run");
        end else begin
            chk({31'h0, pin}, '0, "steady low level");
            chk({31'h0, run_len > WAVE_MS * MS_T}, 32'h1, "steady low length");
        end
    endtask

    task automatic t_alarm;
        wr(A_PRIO_HI, 32'h0000_0901);
        wr(A_PRIO_LO, 32'h0000_1000);
        wr(A_FUNC, 32'h0000_0030);
        rd(A_PRIO_HI, rd_v);
        chk(rd_v, 32'h0000_0901, "priority readback");
        pat(0);
        bf <= 8'h02;
        pat(1);
        rd(A_ALARM, rd_v);
        chk(rd_v & 32'h0000_000B, 32'h0000_0009, "alarm status minor");
        radio_sync <= 1'b0;
        pat(2);
        bf <= 8'h00;
        pat(2);
        radio_sync <= 1'b1;
        src_err <= 16'h0002;
        pat(0);
        src_err <= '0;
        wr(A_FUNC, 32'h0000_0010);
        pat(2);
    endtask

    task automatic t_irq;
        wr(A_IRQ_STAT, 32'h0000_000F);
        wr(A_IRQ_MASK, 32'h0000_0001);
        settle;
        chk({31'h0, irq}, '0, "irq idle");
        radio_sync <= 1'b0;
        settle;
        chk({31'h0, irq}, 32'h1, "irq on major");
        rd(A_IRQ_STAT, rd_v);
        chk(rd_v & 32'h9, 32'h9, "major and new status bits");
        wr(A_IRQ_MASK, '0);
        settle;
        chk({31'h0, irq}, '0, "irq masked");
        radio_sync <= 1'b1;
        settle;
        wr(A_IRQ_STAT, 32'h0000_0001);
        settle;
        rd(A_IRQ_STAT, rd_v);
        chk(rd_v & 32'h5, 32'h4, "status after clear");
        wr(A_IRQ_MASK, 32'h0000_0004);
        settle;
        chk({31'h0, irq}, 32'h1, "irq on return to none");
        wr(A_IRQ_STAT, 32'h0000_0004);
        settle;
        chk({31'h0, irq}, '0, "irq cleared");
        bf <= 8'h02;
        settle;
        rd(A_IRQ_STAT, rd_v);
        chk(rd_v & 32'h2, 32'h2, "minor status bit");
        bf <= 8'h00;
    endtask

    // hang guard: a stuck run ends in the closing report
    initial begin
        repeat (95000) @(posedge ref_clk);
        error_cnt++;
        $display("wrong value at %0t: run timed out", $time);
        wrap_up;
    end

    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        src_err = '0;
        radio_sync = 1'b1;
        bf = '0;
        ba = '0;
        ml = '0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_boards;
        t_alarm;
        t_irq;
        wrap_up;
    end
endmodule
